/* hw/rticc_checker.sv */
/*
 * Command legality checker of a serial-bus remote terminal, with the
 * legality table in flip-flops reachable over APB.
 * Assumes a word decoder on the same clock that presents only words
 * already checked for sync, Manchester, bit count and parity, and that
 * presents a contiguous terminal-to-terminal pair as two words at once.
 */
// Local design decisions: the register offsets and the APB register port.
// Operation
// RQ1 - Table is 256 words at 0x100 to 0x1FF
// RQ2 - Even subaddress word: counts 32, 1..15
// RQ3 - Odd subaddress word: counts 16..31
// RQ4 - Even mode word: mode codes 0..15
// RQ5 - Odd mode word: mode codes 16..31
// RQ6 - Each valid command fetches one table bit
// RQ7 - Bit zero: clear status, full data
// RQ8 - Bit one: status only, message error
// RQ9 - Self test clears table, then ready
// RQ10 - No commands until execution start set
// RQ11 - Separate entries per direction, broadcast, subaddress
// RQ12 - Subaddress 0 or 31 means mode command
// RQ13 - Pair is receive then transmit, not broadcast
// RQ14 - Pair with a mode subaddress is ignored
// RQ15 - First word ours: receiver, flag set
// RQ16 - Second word ours: ordinary transmitter
// RQ17 - Host clears broadcast disable to allow broadcast
// RQ18 - Mode data uses a fixed location
// RQ19 - Separate descriptor per direction and subaddress
// RQ20 - Subaddress 0 and 31 handled alike
// RQ21 - Undefined mode ignored when invalid bit set
// RQ22 - Addressed on own address or broadcast
// RQ23 - Index from direction, subaddress, count MSB, broadcast
// RQ24 - Fetch completes well inside response time
// RQ25 - Lookup only for valid, addressed commands
`timescale 1ns/1ps
`default_nettype none

module rticc_checker
(
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    // Commands from the word decoder.
    input  wire logic        CMD_VALID,
    input  wire logic        CMD_PAIR,
    input  wire logic [15:0] CMD_WORD1,
    input  wire logic [15:0] CMD_WORD2,
    input  wire logic [4:0]  TERM_ADDR,
    // Answer towards the response logic.
    output var  logic        RESP_VALID,
    output var  logic        RESP_MSG_ERROR,
    output var  logic [5:0]  RESP_WORDS,
    output var  logic        RESP_MODE,
    output var  logic        RESP_TRANSMIT,
    output var  logic        RESP_BROADCAST,
    output var  logic        RESP_TERMINAL_TO_TERMINAL_FLAG_FLAG,
    output var  logic [5:0]  RESP_DESC_INDEX,
    output var  logic [5:0]  RESP_MODE_LOC,
    output var  logic        CMD_IGNORED,
    // Device state.
    output var  logic        READY
);

    // Mode command test on a subaddress field.
    function automatic logic is_mode(input logic [4:0] sa);
        is_mode = (sa == rticc_pkg::MODE_SA_LO) ||
                  (sa == rticc_pkg::MODE_SA_HI); // see RQ12 see RQ20
    endfunction

    // Undefined mode command: 0..15, 16, 18, 19 received; 17, 20, 21 sent.
    function automatic logic is_undef(input logic [15:0] w);
        logic [4:0] mc;
        logic       tr;
        mc = w[4:0];
        tr = w[rticc_pkg::TR_POS];
        is_undef = (!tr && (mc < 5'h10 || mc == 5'h10 ||
                            mc == 5'h12 || mc == 5'h13)) ||
                   (tr && (mc == 5'h11 || mc == 5'h14 || mc == 5'h15));
    endfunction

    // Broadcast command test, honouring the broadcast disable bit.
    function automatic logic is_bcast(input logic [15:0] w,
                                      input logic        bc_dis);
        is_bcast = (w[15:11] == rticc_pkg::BCAST_TA) && !bc_dis;
    endfunction

    // Table index: not-broadcast, direction, subaddress, count MSB.
    function automatic logic [7:0] table_index(input logic [15:0] w,
                                               input logic        bc);
        table_index = {!bc, w[10:5], w[4]}; // see RQ11 see RQ23
    endfunction

    // Configuration and status state.
    logic [2:0]                cfg_q;          // Start, bc disable, umc.
    logic                      ready_q;        // Self test finished.
    logic [7:0]                clr_q;          // Self test clear pointer.
    rticc_pkg::rticc_state_type state_q;       // Sequencer state.
    logic                      last_ill_q;     // Last answer was illegal.
    logic                      last_ign_q;     // Last command ignored.
    logic [7:0]                last_idx_q;     // Last table index read.

    // Legality table storage, one 16-bit word per entry.
    logic [15:0] table_q [rticc_pkg::TABLE_WORDS];

    // Latched command and decision.
    logic [15:0]               word_q;
    logic                      bc_q;
    rticc_pkg::rticc_role_type role_q;
    rticc_pkg::rticc_role_type role_d;
    logic [15:0]               word_d;
    logic                      bc_d;

    // APB decode.
    logic       apb_acc;      // Access phase, answer not yet given.
    logic       apb_done;     // Edge at which the transfer completes.
    logic [9:0] apb_idx;      // Register index.
    logic       hit_table;
    logic       hit_cfg;
    logic       hit_sts;
    logic       grant;        // Host may be answered this cycle.
    logic       take;         // A command is accepted this cycle.
    logic       exec_on;
    logic       bc_dis;
    logic       umc_inv;

    assign exec_on  = cfg_q[rticc_pkg::CFG_EXEC_POS];
    assign bc_dis   = cfg_q[rticc_pkg::CFG_BCDIS_POS];
    assign umc_inv  = cfg_q[rticc_pkg::CFG_UMCI_POS];
    assign apb_idx  = PADDR[11:2];
    assign apb_acc  = PSEL && PENABLE && !PREADY;
    assign apb_done = PSEL && PENABLE && PREADY;
    assign hit_table = (apb_idx >= rticc_pkg::TABLE_FIRST) &&
                       (apb_idx <= rticc_pkg::TABLE_LAST); // see RQ1
    assign hit_cfg  = apb_idx == rticc_pkg::CONFIG_IDX;
    assign hit_sts  = apb_idx == rticc_pkg::STATUS_IDX;
    // Commands wait for start and for the self test to finish.
    assign take = CMD_VALID && exec_on && ready_q &&
                  state_q == rticc_pkg::S_IDLE; // see RQ10
    // The host waits while the table is cleared or read for a command,
    // so a table word never changes under the lookup.
    assign grant = apb_acc && ready_q && state_q == rticc_pkg::S_IDLE &&
                   !take; // see RQ24

    // Decide the terminal's role from the presented word or pair.
    always_comb
    begin
        role_d = rticc_pkg::ROLE_IGNORE;
        word_d = CMD_WORD1;
        bc_d   = 1'b0;
        if (!CMD_PAIR)
        begin
            // Single command: own address or broadcast.
            if (CMD_WORD1[15:11] == TERM_ADDR ||
                is_bcast(CMD_WORD1, bc_dis)) // see RQ22 see RQ25
            begin
                if (is_mode(CMD_WORD1[9:5]) && is_undef(CMD_WORD1) &&
                    umc_inv)
                begin
                    // Undefined mode commands treated as invalid.
                    role_d = rticc_pkg::ROLE_IGNORE; // see RQ21
                end
                else if (is_bcast(CMD_WORD1, bc_dis) &&
                         CMD_WORD1[rticc_pkg::TR_POS] &&
                         !is_mode(CMD_WORD1[9:5]))
                begin
                    // A broadcast transmit to a subaddress is never valid.
                    role_d = rticc_pkg::ROLE_IGNORE;
                end
                else
                begin
                    role_d = rticc_pkg::ROLE_PLAIN;
                    bc_d   = is_bcast(CMD_WORD1, bc_dis);
                end
            end
        end
        else if (!CMD_WORD1[rticc_pkg::TR_POS] &&
                 CMD_WORD2[rticc_pkg::TR_POS] &&
                 CMD_WORD2[15:11] != rticc_pkg::BCAST_TA) // see RQ13
        begin
            if (is_mode(CMD_WORD1[9:5]) || is_mode(CMD_WORD2[9:5]))
            begin
                // Mode subaddress in either word spoils the pair.
                role_d = rticc_pkg::ROLE_IGNORE; // see RQ14
            end
            else if (CMD_WORD1[15:11] == TERM_ADDR ||
                     is_bcast(CMD_WORD1, bc_dis))
            begin
                role_d = rticc_pkg::ROLE_TERMINAL_TO_TERMINAL_FLAG_RX; // see RQ15
                bc_d   = is_bcast(CMD_WORD1, bc_dis);
            end
            else if (CMD_WORD2[15:11] == TERM_ADDR)
            begin
                role_d = rticc_pkg::ROLE_TERMINAL_TO_TERMINAL_FLAG_TX; // see RQ16
                word_d = CMD_WORD2;
            end
        end
    end

    // Sequencer: self test clear, idle, one-cycle lookup.
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_q <= rticc_pkg::S_TEST;
            clr_q   <= 8'h00;
            ready_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                rticc_pkg::S_TEST:
                begin
                    // One table word cleared per cycle, then ready.
                    clr_q <= clr_q + 8'h01;
                    if (clr_q == 8'hFF)
                    begin
                        ready_q <= 1'b1; // see RQ9
                        state_q <= rticc_pkg::S_IDLE;
                    end
                end
                rticc_pkg::S_IDLE:
                begin
                    if (take && role_d != rticc_pkg::ROLE_IGNORE)
                    begin
                        state_q <= rticc_pkg::S_LOOK;
                    end
                end
                rticc_pkg::S_LOOK:
                begin
                    state_q <= rticc_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Latch the command chosen for lookup.
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            word_q <= 16'h0000;
            bc_q   <= 1'b0;
            role_q <= rticc_pkg::ROLE_IGNORE;
        end
        else if (take)
        begin
            word_q <= word_d;
            bc_q   <= bc_d;
            role_q <= role_d;
        end
    end

    // Table storage: cleared by self test, written by the host.
    // It has no reset of its own; the self test is what clears it.
    always_ff @(posedge MCLK)
    begin
        if (state_q == rticc_pkg::S_TEST)
        begin
            table_q[clr_q] <= 16'h0000; // see RQ9
        end
        else if (apb_done && PWRITE && hit_table)
        begin
            table_q[apb_idx[7:0]] <= PWDATA[15:0]; // see RQ1
        end
    end

    // Answer generation: one table bit fetched per accepted command.
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RESP_VALID      <= 1'b0;
            RESP_MSG_ERROR  <= 1'b0;
            RESP_WORDS      <= 6'h00;
            RESP_MODE       <= 1'b0;
            RESP_TRANSMIT   <= 1'b0;
            RESP_BROADCAST  <= 1'b0;
            RESP_TERMINAL_TO_TERMINAL_FLAG_FLAG  <= 1'b0;
            RESP_DESC_INDEX <= 6'h00;
            RESP_MODE_LOC   <= 6'h00;
            CMD_IGNORED     <= 1'b0;
            last_ill_q      <= 1'b0;
            last_ign_q      <= 1'b0;
            last_idx_q      <= 8'h00;
        end
        else
        begin
            RESP_VALID  <= 1'b0;
            CMD_IGNORED <= 1'b0;
            if (take && role_d == rticc_pkg::ROLE_IGNORE)
            begin
                // No answer for invalid commands; only the ignore pulse and the ignored status bit are set.
                CMD_IGNORED <= 1'b1; // see RQ14 see RQ21
                last_ign_q  <= 1'b1;
            end
            else if (state_q == rticc_pkg::S_LOOK)
            begin
                // Bit number is the low four count or mode bits; a count
                // of zero lands on bit 0 and means 32 words.
                logic        ill;
                logic        md;
                logic [7:0]  idx;
                idx = table_index(word_q, bc_q);
                ill = table_q[idx][word_q[3:0]]; // see RQ2 see RQ3 see RQ6
                md  = is_mode(word_q[9:5]); // see RQ4 see RQ5
                RESP_VALID     <= 1'b1;
                RESP_MSG_ERROR <= ill; // see RQ8
                if (ill)
                begin
                    RESP_WORDS <= 6'h00; // see RQ8
                end
                else if (md)
                begin
                    // Codes 16..31 carry one data word.
                    RESP_WORDS <= {5'h00, word_q[4]}; // see RQ7
                end
                else if (word_q[4:0] == 5'h00)
                begin
                    RESP_WORDS <= rticc_pkg::FULL_COUNT; // see RQ7
                end
                else
                begin
                    RESP_WORDS <= {1'b0, word_q[4:0]}; // see RQ7
                end
                RESP_MODE       <= md;
                RESP_TRANSMIT   <= word_q[rticc_pkg::TR_POS];
                RESP_BROADCAST  <= bc_q;
                RESP_TERMINAL_TO_TERMINAL_FLAG_FLAG  <= role_q == rticc_pkg::ROLE_TERMINAL_TO_TERMINAL_FLAG_RX;
                RESP_DESC_INDEX <= word_q[10:5]; // see RQ19
                RESP_MODE_LOC   <= {word_q[10], word_q[4:0]}; // see RQ18
                last_ill_q      <= ill;
                last_ign_q      <= 1'b0;
                last_idx_q      <= idx;
            end
        end
    end

    // APB slave: answer one cycle after grant; writes land at completion.
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            cfg_q   <= rticc_pkg::CFG_RESET;
        end
        else
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            if (grant)
            begin
                PREADY  <= 1'b1;
                PSLVERR <= !(hit_table || hit_cfg || hit_sts);
                PRDATA  <= 32'h0000_0000;
                if (hit_table)
                begin
                    PRDATA <= {16'h0000, table_q[apb_idx[7:0]]};
                end
                else if (hit_cfg)
                begin
                    PRDATA <= {29'h0000_0000, cfg_q};
                end
                else if (hit_sts)
                begin
                    PRDATA <= {16'h0000, last_idx_q, 4'h0, last_ign_q,
                               last_ill_q, state_q != rticc_pkg::S_IDLE,
                               ready_q};
                end
            end
            if (apb_done && PWRITE && hit_cfg)
            begin
                // Broadcast stays accepted while the host keeps it clear.
                cfg_q <= PWDATA[2:0]; // see RQ10 see RQ17
            end
        end
    end

    assign READY = ready_q;

    // Helper sequences for the assertions below.
    sequence accepted_s;
        take && role_d != rticc_pkg::ROLE_IGNORE;
    endsequence

    sequence refused_s;
        take && role_d == rticc_pkg::ROLE_IGNORE;
    endsequence

    // An accepted command is answered two edges later.
    lookup_latency_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        accepted_s |-> ##2 RESP_VALID && !CMD_IGNORED) // see RQ6 see RQ24
        else $error("accepted command not answered in two cycles");

    // Answer comes well inside the bus response limit.
    resp_window_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        accepted_s |-> ##[1:40] RESP_VALID) // see RQ24
        else $error("answer later than response limit");

    // Illegal answer carries no data words.
    illegal_nodata_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        RESP_VALID && RESP_MSG_ERROR |-> RESP_WORDS == 6'h00) // see RQ8
        else $error("illegal answer carries data words");

    // Legal subaddress answer transacts at least one word.
    legal_words_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        RESP_VALID && !RESP_MSG_ERROR && !RESP_MODE |-> RESP_WORDS != 6'h00)
        else $error("legal answer without data words"); // see RQ7

    // Error bit equals the fetched table bit.
    error_source_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        state_q == rticc_pkg::S_LOOK |=> RESP_MSG_ERROR ==
        $past(table_q[table_index(word_q, bc_q)][word_q[3:0]])) // see RQ6
        else $error("message error differs from table bit");

    // Nothing is answered before execution start.
    start_gate_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CMD_VALID && !exec_on && state_q == rticc_pkg::S_IDLE
        |-> ##2 !RESP_VALID && !CMD_IGNORED) // see RQ10
        else $error("command handled before execution start");

    // Refused commands raise the ignore pulse and no answer.
    refuse_path_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        refused_s |=> CMD_IGNORED ##1 !RESP_VALID) // see RQ14 see RQ21
        else $error("refused command answered");

    // Ready rises exactly when the last table word is cleared.
    ready_rise_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $rose(READY) |-> $past(clr_q) == 8'hFF) // see RQ9
        else $error("ready without complete table clear");

    // Mode pair is never accepted.
    pair_mode_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        take && CMD_PAIR && (is_mode(CMD_WORD1[9:5]) ||
        is_mode(CMD_WORD2[9:5])) |=> CMD_IGNORED) // see RQ14
        else $error("pair with mode subaddress accepted");

    // Receiver flag only on a receive answer.
    terminal_to_terminal_flag_flag_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        RESP_VALID && RESP_TERMINAL_TO_TERMINAL_FLAG_FLAG |-> !RESP_TRANSMIT) // see RQ15
        else $error("terminal pair flag on transmit answer");

endmodule

`default_nettype wire

/* hw/rticc_pkg.sv */
/*
 * Shared constants and types of the command legality checker.
 * Assumes a single 10 MHz clock and register access over APB.
 */
`default_nettype none

package rticc_pkg;

    // Clock and response timing.
    localparam int CLK_PERIOD_NS   = 100;
    localparam int RESP_LIMIT_NS   = 4000;
    localparam int RESP_LIMIT_CYC  = RESP_LIMIT_NS / CLK_PERIOD_NS;

    // Register indices; the byte address is four times the index.
    localparam logic [9:0] CONFIG_IDX    = 10'h001;
    localparam logic [9:0] STATUS_IDX    = 10'h002;
    localparam logic [9:0] TABLE_FIRST   = 10'h100;
    localparam logic [9:0] TABLE_LAST    = 10'h1FF;
    localparam int         TABLE_WORDS   = 256;

    // Configuration register fields and reset value.
    localparam int          CFG_EXEC_POS  = 0;
    localparam int          CFG_BCDIS_POS = 1;
    localparam int          CFG_UMCI_POS  = 2;
    localparam logic [2:0]  CFG_RESET     = 3'h0;

    // Status register fields.
    localparam int STS_READY_POS   = 0;
    localparam int STS_BUSY_POS    = 1;
    localparam int STS_ILLEGAL_POS = 2;
    localparam int STS_IGNORED_POS = 3;
    localparam int STS_INDEX_POS   = 8;

    // Command word fields.
    localparam int         TA_POS    = 11;
    localparam int         TR_POS    = 10;
    localparam int         SA_POS    = 5;
    localparam logic [4:0] BCAST_TA  = 5'h1F;
    localparam logic [4:0] MODE_SA_LO = 5'h00;
    localparam logic [4:0] MODE_SA_HI = 5'h1F;
    localparam logic [5:0] FULL_COUNT = 6'h20;

    // Main sequencer states.
    typedef enum logic [1:0] {S_TEST, S_IDLE, S_LOOK} rticc_state_type;

    // Role the terminal takes for an accepted command.
    typedef enum logic [1:0] {
        ROLE_IGNORE, ROLE_PLAIN, ROLE_TERMINAL_TO_TERMINAL_FLAG_RX, ROLE_TERMINAL_TO_TERMINAL_FLAG_TX
    } rticc_role_type;

endpackage

`default_nettype wire

/* sim/rticc_bc_model.sv */
/*
 * Bus controller side model: presents validated command words and pairs.
 * Assumes the checker's clock and its registered answer pulses.
 */
`timescale 1ns/1ps
`default_nettype none

module rticc_bc_model
(
    // Clock.
    input  wire logic        clk,
    // Command words towards the checker.
    output var  logic        cmd_valid,
    output var  logic        cmd_pair,
    output var  logic [15:0] cmd_word1,
    output var  logic [15:0] cmd_word2,
    // Answer from the checker.
    input  wire logic        resp_valid,
    input  wire logic        cmd_ignored
);
    // Idle word lines never repeat a stale word, so a late read shows.
    initial
    begin
        cmd_valid = 1'b0;
        cmd_pair  = 1'b0;
        cmd_word1 = 16'hFFFF;
        cmd_word2 = 16'hFFFF;
    end

    // Sends one word or a receive-then-transmit pair after gap idle
    // cycles, then watches eight cycles for an answer or a drop.
    task automatic send(input int gap, input logic pair,
                        input logic [15:0] w1, input logic [15:0] w2,
                        output logic answered, output logic ignored);
        answered = 1'b0;
        ignored  = 1'b0;
        repeat (gap) @(posedge clk);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_pair  <= pair;
        cmd_word1 <= w1;
        cmd_word2 <= w2;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_pair  <= 1'b0;
        cmd_word1 <= ~w1;
        cmd_word2 <= ~w2;
        repeat (8)
        begin
            @(negedge clk);
            answered = answered | resp_valid;
            ignored  = ignored | cmd_ignored;
        end
    endtask
endmodule

`default_nettype wire

/* sim/tb_top.sv */
/*
 * Self-checking bench of the command legality checker.
 * Assumes the checker's APB map and the bus controller model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // Clock, reset and APB master signals.
    logic        mclk = 1'b0, sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, ans, ign, ready;
    // Command and answer signals; the own address is the only tie.
    logic        cmd_valid, cmd_pair, resp_valid, resp_msg_error;
    logic [15:0] cmd_word1, cmd_word2, w;
    logic [4:0]  term_addr = 5'h05;
    logic [5:0]  resp_words, desc_index, mode_loc, nw;
    logic        resp_mode, resp_tx, resp_bc, resp_terminal_to_terminal_flag, cmd_ignored, e;
    logic [9:0]  idx;
    logic [15:0] val;
    int          mismatches = 0, compares = 0, i;
    // Rows: table index, table word, command, message error, data words.
    logic [48:0] rows [12] = '{
        {10'h1C2, 16'h0001, 16'h2C20, 1'b1, 6'h00},
        {10'h1C2, 16'h8000, 16'h2C2F, 1'b1, 6'h00},
        {10'h1C2, 16'h8000, 16'h2C2E, 1'b0, 6'h0E},
        {10'h1C3, 16'h0001, 16'h2C30, 1'b1, 6'h00},
        {10'h1C3, 16'h8000, 16'h2C3F, 1'b1, 6'h00},
        {10'h1C0, 16'h0004, 16'h2C02, 1'b1, 6'h00},
        {10'h1FF, 16'h0002, 16'h2FF1, 1'b1, 6'h00},
        {10'h1FF, 16'h0002, 16'h2FF0, 1'b0, 6'h01},
        {10'h1C1, 16'h0002, 16'h2C11, 1'b1, 6'h00},
        {10'h102, 16'h0008, 16'hF823, 1'b1, 6'h00},
        {10'h182, 16'h0000, 16'h2823, 1'b0, 6'h03},
        {10'h182, 16'h0000, 16'h2820, 1'b0, 6'h20}};

    rticc_checker uut (.MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CMD_VALID(cmd_valid), .CMD_PAIR(cmd_pair), .CMD_WORD1(cmd_word1),
        .CMD_WORD2(cmd_word2), .TERM_ADDR(term_addr),
        .RESP_VALID(resp_valid), .RESP_MSG_ERROR(resp_msg_error),
        .RESP_WORDS(resp_words), .RESP_MODE(resp_mode),
        .RESP_TRANSMIT(resp_tx), .RESP_BROADCAST(resp_bc),
        .RESP_TERMINAL_TO_TERMINAL_FLAG_FLAG(resp_terminal_to_terminal_flag), .RESP_DESC_INDEX(desc_index),
        .RESP_MODE_LOC(mode_loc), .CMD_IGNORED(cmd_ignored), .READY(ready));

    rticc_bc_model bc (.clk(mclk), .cmd_valid(cmd_valid),
        .cmd_pair(cmd_pair), .cmd_word1(cmd_word1), .cmd_word2(cmd_word2),
        .resp_valid(resp_valid), .cmd_ignored(cmd_ignored));

    // Free-running 10 MHz clock.
    always #50 mclk = ~mclk;

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Counts one comparison and reports a difference at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request holds until PREADY is sampled high.
    task automatic apb(input logic wr, input logic [9:0] ix,
                       input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {ix, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 400 && pready !== 1'b1; n++)
            @(posedge mclk);
        if (pready !== 1'b1)
        begin
            mismatches++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sets the configuration, sends, and checks answer and drop pulses.
    task automatic cmd(input logic [2:0] cfg, input logic pr,
                       input logic [15:0] w1, input logic [15:0] w2,
                       input logic ea, input logic ei);
        apb(1'b1, 10'h001, {29'h0, cfg});
        bc.send(1, pr, w1, w2, ans, ign);
        chk(ans, ea);
        chk(ign, ei);
    endtask

    // Main sequence: reset and self test, table rows, then odd cases.
    initial
    begin
        // Outputs are only defined once the first edge has seen reset.
        repeat (4) @(posedge mclk);
        chk({ready, pready, resp_valid, cmd_ignored}, 4'h0);
        sys_rst <= 1'b0;
        repeat (100) @(posedge mclk);
        chk(ready, 1'b0);
        for (i = 0; i < 300 && ready !== 1'b1; i++)
            @(posedge mclk);
        chk(ready, 1'b1);
        if (ready !== 1'b1)
            conclude();
        apb(1'b0, 10'h100, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 10'h1FF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 10'h001, 32'h0);
        chk(rd, 32'h0);
        // Just outside the table both sides must be refused.
        for (i = 0; i < 2; i++)
        begin
            apb(1'b0, i ? 10'h200 : 10'h0FF, 32'h0);
            chk(err, 1'b1);
            chk(rd, 32'h0);
        end
        bc.send(0, 1'b0, 16'h2821, 16'h0000, ans, ign);
        chk({ans, ign}, 2'h0);
        apb(1'b1, 10'h001, 32'h1);
        for (i = 0; i < 12; i++)
        begin
            {idx, val, w, e, nw} = rows[i];
            apb(1'b1, idx, {16'h0000, val});
            bc.send(i % 3, 1'b0, w, 16'h0000, ans, ign);
            chk({ans, resp_msg_error}, {1'b1, e});
            chk(resp_words, nw);
            chk({resp_bc, resp_mode, desc_index, mode_loc},
                {!idx[7], (w[9:5] == 5'h00) || (w[9:5] == 5'h1F),
                 w[10:5], w[10], w[4:0]});
            apb(1'b0, 10'h002, 32'h0);
            chk({rd[15:8], rd[2]}, {idx[7:0], e});
        end
        cmd(3'h1, 1'b1, 16'h2844, 16'h1C64, 1'b1, 1'b0);
        chk({resp_terminal_to_terminal_flag, resp_tx}, 2'h2);
        cmd(3'h1, 1'b1, 16'h1844, 16'h2C64, 1'b1, 1'b0);
        chk({resp_terminal_to_terminal_flag, resp_tx}, 2'h1);
        cmd(3'h1, 1'b1, 16'h2844, 16'h1C04, 1'b0, 1'b1);
        cmd(3'h1, 1'b1, 16'h1844, 16'hFC64, 1'b0, 1'b1);
        cmd(3'h1, 1'b0, 16'h3023, 16'h0000, 1'b0, 1'b1);
        cmd(3'h5, 1'b0, 16'h2800, 16'h0000, 1'b0, 1'b1);
        cmd(3'h1, 1'b0, 16'h2800, 16'h0000, 1'b1, 1'b0);
        cmd(3'h3, 1'b0, 16'hF823, 16'h0000, 1'b0, 1'b1);
        // A second reset mid-run must clear the table and the start bit.
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        chk({ready, resp_valid}, 2'h0);
        sys_rst <= 1'b0;
        for (i = 0; i < 300 && ready !== 1'b1; i++)
            @(posedge mclk);
        apb(1'b0, 10'h1C2, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 10'h001, 32'h0);
        chk(rd, 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
